// ===== pcm_ctrl.sv
/*
 * CPU power-mode controller with an APB register slave.
 * Assumes the CPU pulses insn_done when an instruction completes and
 * that irq_pending is already qualified by the interrupt enables.
 */
// The APB register port was left to the implementer.
`timescale 1ns/1ns
module pcm_ctrl
    import pcm_pkg::*;
#(
    parameter int unsigned MCD_CYCLES = PCM_MCD_CYCLES
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [PCM_ADDR_W-1:0] paddr,
    input  wire logic [31:0]           pwdata,
    output logic [31:0]                prdata,
    output logic                       pready,
    output logic                       pslverr,
    input  wire logic                  insn_done,
    input  wire logic                  irq_pending,
    input  wire logic                  wdt_timeout,
    input  wire logic                  ext_rst_pin_n,
    input  wire logic                  wake_event,
    output logic                       cpu_clk_en,
    output logic                       periph_clk_en,
    output logic                       osc_en,
    output logic                       core_rst,
    output logic [15:0]                boot_addr,
    output logic                       wake_irq
);

    //======================================================================
    // State.
    typedef struct packed {
        pcm_state_t  st;
        logic        idle_pend;
        logic        stop_pend;
        logic        susp_pend;
        logic        mcd_en;
        logic [3:0]  cause;
        logic [2:0]  rst_cnt;
        logic        cpu_clk_en;
        logic        periph_clk_en;
        logic        osc_en;
        logic        core_rst;
        logic [15:0] boot_addr;
        logic        wake_irq;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pcm_main_t;

    localparam pcm_main_t RESET_STATE = '{
        st:            PCM_ST_RESET,
        idle_pend:     1'b0,
        stop_pend:     1'b0,
        susp_pend:     1'b0,
        mcd_en:        1'b0,
        cause:         4'h0,
        rst_cnt:       3'h0,
        cpu_clk_en:    1'b0,
        periph_clk_en: 1'b1,
        osc_en:        1'b1,
        core_rst:      1'b1,
        boot_addr:     PCM_RESET_VECTOR,
        wake_irq:      1'b0,
        pready:        1'b0,
        pslverr:       1'b0,
        prdata:        32'h0000_0000
    };

    pcm_main_t q;
    pcm_main_t d;

    logic ext_rst_n_s;
    logic mcd_done;
    logic rst_src;
    logic wr_acc;
    logic [3:0] cause_set;

    //======================================================================
    // Pin synchroniser and clock loss detector.
    pcm_sync3 #(
        .RESET_VAL (1'b1)
    ) u_rst_sync (
        .clk    (clk),
        .arst_n (arst_n),
        .din    (ext_rst_pin_n),
        .dout   (ext_rst_n_s)
    );

    // The detector only counts while the system clock is meant to be
    // stopped, so a long Stop ends in a reset only if software enables it.
    pcm_timeout #(
        .LIMIT (MCD_CYCLES)
    ) u_mcd (
        .clk    (clk),
        .arst_n (arst_n),
        .en     (q.st == PCM_ST_STOP && q.mcd_en), // RL12
        .done   (mcd_done)
    );

    function automatic logic hit(input logic [PCM_ADDR_W-1:0] a, input logic [7:0] idx);
        hit = (a == pcm_byte_addr(idx));
    endfunction

    //======================================================================
    // Next state.
    always_comb begin
        d          = q;
        d.pready   = 1'b0;
        d.pslverr  = 1'b0;
        d.wake_irq = 1'b0;
        cause_set  = 4'h0;
        wr_acc     = psel && penable && q.pready && pwrite && !q.pslverr;
        rst_src    = !ext_rst_n_s || mcd_done || (wdt_timeout && q.st != PCM_ST_STOP); // RL7

        // Answer in the first access cycle; read data are set up one
        // cycle early so that they leave straight from a flop.
        if (psel && !penable) begin
            d.pready  = 1'b1;
            d.pslverr = !(hit(paddr, PCM_IDX_PMC) || hit(paddr, PCM_IDX_STATUS)
                        || hit(paddr, PCM_IDX_CTRL));
            d.prdata  = 32'h0000_0000; // RL14 RL15
            if (hit(paddr, PCM_IDX_STATUS)) begin
                d.prdata = {24'h000000, q.cause, 1'b0, q.st};
            end else if (hit(paddr, PCM_IDX_CTRL)) begin
                d.prdata = {31'h0, q.mcd_en};
            end
        end

        // Mode bits are triggers only; the reserved bits are dropped.
        if (wr_acc && hit(paddr, PCM_IDX_PMC) && q.st == PCM_ST_RUN) begin
            if (pwdata[PCM_PMC_STOP_BIT]) begin
                d.stop_pend = 1'b1; // RL9 RL17
                d.idle_pend = 1'b0; // RL17
            end else if (pwdata[PCM_PMC_IDLE_BIT]) begin
                d.idle_pend = 1'b1; // RL1
            end
        end
        if (wr_acc && hit(paddr, PCM_IDX_CTRL)) begin
            d.mcd_en = pwdata[PCM_CTRL_MCD_BIT];
            if (pwdata[PCM_CTRL_SUSP_BIT] && q.st == PCM_ST_RUN) begin
                d.susp_pend = 1'b1; // RL16
            end
        end

        unique case (q.st)
            PCM_ST_RESET: begin
                if (q.rst_cnt == PCM_RESET_HOLD - 3'h1) begin
                    d.st        = PCM_ST_RUN;
                    d.boot_addr = PCM_RESET_VECTOR; // RL6 RL11
                end else begin
                    d.rst_cnt = q.rst_cnt + 3'h1;
                end
            end
            PCM_ST_RUN: begin
                // The request waits for the writing instruction to finish.
                if (insn_done && q.stop_pend) begin
                    d.st        = PCM_ST_STOP; // RL9 RL17
                    d.stop_pend = 1'b0;
                    d.idle_pend = 1'b0;
                end else if (insn_done && q.idle_pend) begin
                    d.st = PCM_ST_IDLE; // RL1
                end else if (insn_done && q.susp_pend) begin
                    d.st        = PCM_ST_SUSPEND; // RL16
                    d.susp_pend = 1'b0;
                end
            end
            PCM_ST_IDLE: begin
                // Nothing but the mode changes here, so all core state
                // and memory are held as they were.
                if (irq_pending) begin
                    d.st        = PCM_ST_RUN; // RL2 RL4 RL5
                    d.idle_pend = 1'b0; // RL5
                    d.wake_irq  = 1'b1;
                    cause_set[3] = 1'b1;
                end
            end
            PCM_ST_STOP: begin
                // Interrupts and the watchdog are dead here; only a reset
                // source leaves this state.
                d.st = PCM_ST_STOP; // RL11
            end
            PCM_ST_SUSPEND: begin
                if (wake_event) begin
                    d.st = PCM_ST_RUN; // RL16
                end
            end
            default: begin
                // An illegal code falls back into the reset sequence
                // instead of leaving the core stuck with no clock.
                d.st      = PCM_ST_RESET;
                d.rst_cnt = 3'h0;
            end
        endcase

        if (rst_src) begin
            d.st        = PCM_ST_RESET; // RL4 RL6 RL11
            d.rst_cnt   = 3'h0;
            d.idle_pend = 1'b0;
            d.stop_pend = 1'b0;
            d.susp_pend = 1'b0;
            cause_set[0] = wdt_timeout && q.st != PCM_ST_STOP;
            cause_set[1] = mcd_done;
            cause_set[2] = !ext_rst_n_s;
        end

        // Write one clears a cause; a new event in the same cycle wins.
        if (wr_acc && hit(paddr, PCM_IDX_STATUS)) begin
            d.cause = q.cause & ~pwdata[PCM_STAT_CAUSE_LO +: 4];
        end
        d.cause = d.cause | cause_set;

        // Outputs follow the next state so they change with it.
        unique case (d.st)
            PCM_ST_RESET: begin
                d.cpu_clk_en    = 1'b0;
                d.periph_clk_en = 1'b1;
                d.osc_en        = 1'b1;
                d.core_rst      = 1'b1; // RL6
            end
            PCM_ST_RUN: begin
                d.cpu_clk_en    = 1'b1;
                d.periph_clk_en = 1'b1;
                d.osc_en        = 1'b1;
                d.core_rst      = 1'b0;
            end
            PCM_ST_IDLE: begin
                d.cpu_clk_en    = 1'b0; // RL3
                d.periph_clk_en = 1'b1; // RL3
                d.osc_en        = 1'b1;
                d.core_rst      = 1'b0;
            end
            PCM_ST_STOP, PCM_ST_SUSPEND: begin
                d.cpu_clk_en    = 1'b0; // RL10
                d.periph_clk_en = 1'b0; // RL10
                d.osc_en        = 1'b0; // RL10 RL16
                d.core_rst      = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= RESET_STATE;
        end else begin
            q <= d;
        end
    end

    assign prdata        = q.prdata;
    assign pready        = q.pready;
    assign pslverr       = q.pslverr;
    assign cpu_clk_en    = q.cpu_clk_en;
    assign periph_clk_en = q.periph_clk_en;
    assign osc_en        = q.osc_en;
    assign core_rst      = q.core_rst;
    assign boot_addr     = q.boot_addr;
    assign wake_irq      = q.wake_irq;

    //======================================================================
    // Checks.
    default clocking cb @(posedge clk); endclocking
    default disable iff (!arst_n);

    sequence s_reset_hold;
        core_rst[*4] ##1 (q.st == PCM_ST_RUN || core_rst);
    endsequence

    chk_idle_entry: assert property ( // RL1
        q.st == PCM_ST_RUN && q.idle_pend && !q.stop_pend && insn_done && !rst_src
        |=> q.st == PCM_ST_IDLE && !cpu_clk_en)
        else $error("idle not entered after instruction");

    chk_idle_clocks: assert property ( // RL3
        q.st == PCM_ST_IDLE |-> !cpu_clk_en && periph_clk_en && osc_en)
        else $error("idle clocks wrong");

    chk_idle_irq_wake: assert property ( // RL5
        q.st == PCM_ST_IDLE && irq_pending && !rst_src
        |=> q.st == PCM_ST_RUN && cpu_clk_en && wake_irq && !q.idle_pend)
        else $error("idle did not wake on interrupt");

    chk_idle_hold: assert property ( // RL4
        q.st == PCM_ST_IDLE && !irq_pending && !rst_src |=> q.st == PCM_ST_IDLE)
        else $error("idle left without cause");

    chk_stop_clocks: assert property ( // RL10
        q.st == PCM_ST_STOP |-> !cpu_clk_en && !periph_clk_en && !osc_en)
        else $error("stop clocks still running");

    chk_stop_irq_ignored: assert property ( // RL11
        q.st == PCM_ST_STOP && !rst_src |=> q.st == PCM_ST_STOP)
        else $error("stop left without reset");

    chk_reset_sequence: assert property ( // RL6
        rst_src |=> s_reset_hold)
        else $error("reset sequence too short");

    chk_wdt_in_idle: assert property ( // RL7
        q.st == PCM_ST_IDLE && wdt_timeout |=> q.st == PCM_ST_RESET && core_rst)
        else $error("watchdog did not reset idle");

    chk_mcd_in_stop: assert property ( // RL12
        mcd_done |=> core_rst ##1 $past(q.st) == PCM_ST_RESET)
        else $error("clock loss did not reset");

    chk_mode_read_zero: assert property ( // RL14
        psel && !penable && !pwrite && hit(paddr, PCM_IDX_PMC)
        |=> pready && prdata == 32'h0000_0000)
        else $error("mode register read not zero");

    chk_stop_wins: assert property ( // RL17
        wr_acc && hit(paddr, PCM_IDX_PMC) && q.st == PCM_ST_RUN
        && pwdata[PCM_PMC_STOP_BIT] && !rst_src
        |=> q.stop_pend && !q.idle_pend)
        else $error("stop did not win over idle");

    chk_suspend_wake: assert property ( // RL16
        q.st == PCM_ST_SUSPEND && wake_event && !rst_src
        |=> q.st == PCM_ST_RUN && osc_en)
        else $error("suspend did not wake");

    sequence s_stop_request;
        q.st == PCM_ST_RUN && q.stop_pend && insn_done && !rst_src;
    endsequence

    chk_stop_entry: assert property ( // RL9
        s_stop_request |=> q.st == PCM_ST_STOP && !osc_en && !cpu_clk_en)
        else $error("stop not entered after instruction");

    chk_reserved_zero: assert property ( // RL15
        pready |-> prdata[31:8] == 24'h000000)
        else $error("reserved read bits not zero");

    chk_reset_release: assert property ( // RL11
        q.st == PCM_ST_RESET && q.rst_cnt == PCM_RESET_HOLD - 3'h1 && !rst_src
        |=> !core_rst && cpu_clk_en && boot_addr == PCM_RESET_VECTOR)
        else $error("core not released at reset vector");

endmodule

// ===== pcm_pkg.sv
/*
 * Constants, register map and types for the CPU power-mode controller.
 * Assumes a 20 MHz system clock that keeps running for this block in every mode.
 */
//==========================================================================
// Operation
// RL1: Idle bit write halts CPU after instruction
// RL2: Idle keeps all registers and memory intact
// RL3: Idle gates only the CPU clock
// RL4: Enabled interrupt or reset ends Idle
// RL5: Interrupt wake clears idle bit, resumes CPU
// RL6: Reset ends Idle, runs reset, fetch zero
// RL7: Watchdog timeout resets out of Idle
// RL8: Software follows idle write with multibyte opcode
// RL9: Stop bit write enters Stop after instruction
// RL10: Stop halts CPU, oscillators, clocks, peripherals
// RL11: Only reset ends Stop, fetch from zero
// RL12: Clock loss detector resets out of Stop
// RL13: Software shuts analog peripherals before Stop
// RL14: Mode bits are triggers, always read zero
// RL15: Reserved bits read zero, write zero
// RL16: Oscillator suspend until a wake event
// RL17: Both bits written means Stop wins
package pcm_pkg;

    //======================================================================
    // Register map: printed offsets are indices, byte address is four times.
    localparam int unsigned    PCM_ADDR_W     = 12;
    localparam logic [7:0]     PCM_IDX_PMC    = 8'h87;
    localparam logic [7:0]     PCM_IDX_STATUS = 8'h88;
    localparam logic [7:0]     PCM_IDX_CTRL   = 8'h89;
    localparam logic [7:0]     PCM_PMC_RESET  = 8'h00;

    //======================================================================
    // Field positions.
    localparam int unsigned    PCM_PMC_IDLE_BIT  = 0;
    localparam int unsigned    PCM_PMC_STOP_BIT  = 1;
    localparam int unsigned    PCM_CTRL_MCD_BIT  = 0;
    localparam int unsigned    PCM_CTRL_SUSP_BIT = 1;
    localparam int unsigned    PCM_STAT_CAUSE_LO = 4;

    //======================================================================
    // Timing.
    localparam int unsigned    PCM_CLK_MHZ        = 20;
    localparam int unsigned    PCM_MCD_TIMEOUT_US = 100;
    localparam int unsigned    PCM_MCD_CYCLES     = PCM_MCD_TIMEOUT_US * PCM_CLK_MHZ;
    localparam logic [2:0]     PCM_RESET_HOLD     = 3'h4;
    localparam logic [15:0]    PCM_RESET_VECTOR   = 16'h0000;

    typedef enum logic [2:0] {
        PCM_ST_RESET,
        PCM_ST_RUN,
        PCM_ST_IDLE,
        PCM_ST_STOP,
        PCM_ST_SUSPEND
    } pcm_state_t;

    function automatic logic [PCM_ADDR_W-1:0] pcm_byte_addr(input logic [7:0] idx);
        pcm_byte_addr = {2'b00, idx, 2'b00};
    endfunction

endpackage

// ===== pcm_sync3.sv
/*
 * Three-stage synchroniser for a level from outside the clock domain.
 * The output changes only once the second and third stages agree.
 */
`timescale 1ns/1ns
module pcm_sync3
    import pcm_pkg::*;
#(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic din,
    output logic      dout
);

    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic out;
    } pcm_sync_t;

    pcm_sync_t q;
    pcm_sync_t d;

    always_comb begin
        d    = q;
        d.s1 = din;
        d.s2 = q.s1;
        d.s3 = q.s2;
        if (q.s2 == q.s3) begin
            d.out = q.s3;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= {4{RESET_VAL}};
        end else begin
            q <= d;
        end
    end

    assign dout = q.out;

endmodule

// ===== pcm_tb.sv
/*
 * Self-checking testbench for the CPU power-mode controller.
 * Assumes the controller answers APB with a one-cycle pready and that
 * the clock-loss count is shortened through the MCD_CYCLES parameter.
 */
`timescale 1ns/1ns
module testbench
    import pcm_pkg::*;
;
    //======================================================================
    // Signals and instance
    localparam int unsigned     MCD_P  = 8;
    localparam logic [11:0]     A_PMC  = {2'b00, PCM_IDX_PMC, 2'b00};
    localparam logic [11:0]     A_STAT = {2'b00, PCM_IDX_STATUS, 2'b00};
    localparam logic [11:0]     A_CTRL = {2'b00, PCM_IDX_CTRL, 2'b00};
    logic                       clk;
    logic                       arst_n;
    logic                       psel;
    logic                       penable;
    logic                       pwrite;
    logic [PCM_ADDR_W-1:0]      paddr;
    logic [31:0]                pwdata;
    logic [31:0]                prdata;
    logic                       pready;
    logic                       pslverr;
    logic                       insn_done;
    logic                       irq_pending;
    logic                       wdt_timeout;
    logic                       ext_rst_pin_n;
    logic                       wake_event;
    logic                       cpu_clk_en;
    logic                       periph_clk_en;
    logic                       osc_en;
    logic                       core_rst;
    logic [15:0]                boot_addr;
    logic                       wake_irq;
    logic [31:0]                rd;
    logic                       er;
    int                         checks;
    int                         err_count;

    pcm_ctrl #(.MCD_CYCLES(MCD_P)) dut_u (
        .clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .insn_done(insn_done),
        .irq_pending(irq_pending), .wdt_timeout(wdt_timeout),
        .ext_rst_pin_n(ext_rst_pin_n), .wake_event(wake_event),
        .cpu_clk_en(cpu_clk_en), .periph_clk_en(periph_clk_en),
        .osc_en(osc_en), .core_rst(core_rst), .boot_addr(boot_addr),
        .wake_irq(wake_irq)
    );

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    //======================================================================
    // Shared tasks
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks, err_count);
        if (err_count == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= wd;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            err_count++;
            give_verdict();
        end
    endtask

    // The wait is bounded so a design that never leaves reset ends the run.
    task automatic wait_rst(input logic lvl, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            #1;
            n++;
        end while (!(core_rst === lvl && (lvl || cpu_clk_en === 1'b1)) && n < lim);
        // Judge the last sample, not the count, so a hit on the final try passes.
        if (!(core_rst === lvl && (lvl || cpu_clk_en === 1'b1))) begin
            err_count++;
            give_verdict();
        end
    endtask

    // The instruction pulse is the moment a pending mode may start.
    task automatic step_insn;
        @(posedge clk);
        insn_done <= 1'b1;
        @(posedge clk);
        insn_done <= 1'b0;
        #1;
    endtask

    task automatic pulse_irq;
        @(posedge clk);
        irq_pending <= 1'b1;
        @(posedge clk);
        irq_pending <= 1'b0;
        #1;
    endtask

    //======================================================================
    // Scenarios
    task automatic t_reset;
        chk(core_rst, 1'b1);
        chk(cpu_clk_en, 1'b0);
        @(posedge clk);
        arst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(core_rst, 1'b1);
        wait_rst(1'b0, 12);
        chk(boot_addr, PCM_RESET_VECTOR);
        apb(1'b0, A_PMC, 32'h0);
        chk(rd, 32'h0);
        chk(er, 1'b0);
        apb(1'b0, 12'h300, 32'h0);
        chk(er, 1'b1);
        chk(rd, 32'h0);
        $display("test reset done");
    endtask

    task automatic t_idle;
        apb(1'b1, A_PMC, 32'h1);
        apb(1'b0, A_PMC, 32'h0);
        chk(rd, 32'h0);
        chk(cpu_clk_en, 1'b1);
        // No interrupt is raised until the idle-setting instruction is done.
        step_insn();
        chk(cpu_clk_en, 1'b0);
        chk(periph_clk_en, 1'b1);
        chk(osc_en, 1'b1);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h7, 32'h2);
        pulse_irq();
        chk(cpu_clk_en, 1'b1);
        chk(wake_irq, 1'b1);
        @(posedge clk);
        #1;
        chk(wake_irq, 1'b0);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h87, 32'h81);
        apb(1'b1, A_STAT, 32'hf0);
        $display("test idle done");
    endtask

    task automatic t_idle_wdt;
        apb(1'b1, A_PMC, 32'h1);
        step_insn();
        chk(cpu_clk_en, 1'b0);
        @(posedge clk);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        wait_rst(1'b1, 4);
        wait_rst(1'b0, 12);
        chk(boot_addr, PCM_RESET_VECTOR);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h17, 32'h11);
        apb(1'b1, A_STAT, 32'hf0);
        $display("test idle watchdog done");
    endtask

    task automatic t_stop_mcd;
        apb(1'b1, A_CTRL, 32'h1);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd & 32'h3, 32'h1);
        // No analog parts are modelled, so none is left on before Stop.
        apb(1'b1, A_PMC, 32'h3);
        step_insn();
        chk(cpu_clk_en, 1'b0);
        chk(osc_en, 1'b0);
        chk(periph_clk_en, 1'b0);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h7, 32'h3);
        pulse_irq();
        chk(cpu_clk_en, 1'b0);
        wait_rst(1'b1, MCD_P + 10);
        wait_rst(1'b0, 12);
        chk(boot_addr, PCM_RESET_VECTOR);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h27, 32'h21);
        apb(1'b1, A_STAT, 32'hf0);
        apb(1'b1, A_CTRL, 32'h0);
        $display("test stop clock loss done");
    endtask

    task automatic t_stop_pin;
        apb(1'b1, A_PMC, 32'h2);
        step_insn();
        chk(osc_en, 1'b0);
        @(posedge clk);
        wdt_timeout <= 1'b1;
        @(posedge clk);
        wdt_timeout <= 1'b0;
        repeat (2 * MCD_P) @(posedge clk);
        #1;
        chk(core_rst, 1'b0);
        chk(osc_en, 1'b0);
        @(posedge clk);
        ext_rst_pin_n <= 1'b0;
        wait_rst(1'b1, 10);
        @(posedge clk);
        ext_rst_pin_n <= 1'b1;
        wait_rst(1'b0, 16);
        chk(boot_addr, PCM_RESET_VECTOR);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h47, 32'h41);
        apb(1'b1, A_STAT, 32'hf0);
        $display("test stop pin done");
    endtask

    task automatic t_suspend;
        apb(1'b1, A_CTRL, 32'h2);
        apb(1'b0, A_CTRL, 32'h0);
        chk(rd & 32'h3, 32'h0);
        step_insn();
        chk(osc_en, 1'b0);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h7, 32'h4);
        @(posedge clk);
        wake_event <= 1'b1;
        @(posedge clk);
        wake_event <= 1'b0;
        #1;
        chk(osc_en, 1'b1);
        apb(1'b0, A_STAT, 32'h0);
        chk(rd & 32'h7, 32'h1);
        $display("test suspend done");
    endtask

    //======================================================================
    // Main sequence
    initial begin
        checks        = 0;
        err_count     = 0;
        arst_n        = 1'b0;
        psel          = 1'b0;
        penable       = 1'b0;
        pwrite        = 1'b0;
        paddr         = '0;
        pwdata        = '0;
        insn_done     = 1'b0;
        irq_pending   = 1'b0;
        wdt_timeout   = 1'b0;
        ext_rst_pin_n = 1'b1;
        wake_event    = 1'b0;
        repeat (20) @(posedge clk);
        #1;
        t_reset();
        t_idle();
        t_idle_wdt();
        t_stop_mcd();
        t_stop_pin();
        t_suspend();
        give_verdict();
    end

endmodule

// ===== pcm_timeout.sv
/*
 * Timeout counter: pulses done for one cycle after every LIMIT enabled cycles.
 * Dropping the enable restarts the count from zero.
 */
`timescale 1ns/1ns
module pcm_timeout
    import pcm_pkg::*;
#(
    parameter int unsigned LIMIT = PCM_MCD_CYCLES
) (
    input  wire logic clk,
    input  wire logic arst_n,
    input  wire logic en,
    output logic      done
);

    typedef struct packed {
        logic [15:0] cnt;
        logic        done;
    } pcm_tmo_t;

    pcm_tmo_t q;
    pcm_tmo_t d;

    always_comb begin
        d      = q;
        d.done = 1'b0;
        if (!en) begin
            d.cnt = 16'h0000;
        end else if (q.cnt == 16'(LIMIT - 1)) begin
            d.cnt  = 16'h0000;
            d.done = 1'b1;
        end else begin
            d.cnt = q.cnt + 16'h0001;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    assign done = q.done;

endmodule
